// ---- core/spc_top.sv ----
`timescale 1ns/100ps
module spc_top
   import spc_pkg::*;
#(
   parameter spc_variant_t VARIANT = SPC_VAR_PRE8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire spc_bus_t bus,
   output logic [15:0] rdata,
   input wire spc_op_t pstack_op,
   input wire spc_op_t rstack_op,
   output logic [7:0] pstack_addr,
   output logic [7:0] rstack_addr,
   output logic [1:0] underflow_req
);
   typedef struct packed {
      logic [15:0] rdata;
   } spc_top_state_t;

   spc_top_state_t state_reg;
   spc_top_state_t state_next;
   logic hit_wr;
   logic hit_rd;
   logic [7:0] psp;
   logic [7:0] rsp;
   logic [15:0] packed_ptrs;
   spc_op_t p_op_eff;
   spc_op_t ch_op [2];
   logic [7:0] ch_ptr [2];
   logic [7:0] ch_addr [2];

   // Decode of the single register address
   assign hit_wr = bus.wr && (bus.addr == SPC_ADDR_STACK_POINTERS);
   assign hit_rd = bus.rd && (bus.addr == SPC_ADDR_STACK_POINTERS);

   // A register read delivers its value onto the parameter stack, so it is a push
   always_comb begin
      p_op_eff = pstack_op;
      p_op_eff.push = pstack_op.push | hit_rd;
   end

   // Index 0 serves the parameter stack, index 1 the return stack
   assign ch_op[0] = p_op_eff;
   assign ch_op[1] = rstack_op;

   // Two identical controllers; only the operand source and field position differ
   for (genvar ch = 0; ch < 2; ch++) begin : g_stack
      localparam int LSB = (ch == 0) ? SPC_PSP_LSB : SPC_RSP_LSB;
      spc_ctrl #(.VARIANT(VARIANT)) u_ctrl (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .op(ch_op[ch]),
         .load(hit_wr),
         .load_val(bus.wdata[LSB +: SPC_FIELD_W]),
         .ptr(ch_ptr[ch]),
         .mem_addr(ch_addr[ch]),
         .underflow(underflow_req[ch])
      );
   end

   // Named views of the array keep the packing and the checks readable
   assign psp = ch_ptr[0];
   assign rsp = ch_ptr[1];
   assign pstack_addr = ch_addr[0];
   assign rstack_addr = ch_addr[1];

   // Pack pointers; unused bits read zero through the controller mask
   assign packed_ptrs = {rsp, psp};

   // Read data is captured from the pointers before the read's own push lands
   always_comb begin
      state_next = state_reg;
      if (hit_rd) begin
         state_next.rdata = packed_ptrs;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '{rdata: SPC_RESET_VALUE};
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;

   property p_read_value;
      @(posedge sys_clk) disable iff (!resetn)
      hit_rd |=> rdata == $past(packed_ptrs);
   endproperty
   a_read_value: assert property (p_read_value) else $error("read data mismatch");

   property p_read_push;
      @(posedge sys_clk) disable iff (!resetn)
      (hit_rd && !hit_wr && !pstack_op.pop) |=> psp != $past(psp);
   endproperty
   a_read_push: assert property (p_read_push) else $error("read did not push");

   property p_write_both;
      @(posedge sys_clk) disable iff (!resetn)
      (hit_wr && VARIANT != SPC_VAR_POST6) |=> packed_ptrs == $past(bus.wdata);
   endproperty
   a_write_both: assert property (p_write_both) else $error("write not loaded");

   // A 6-bit build drops the upper bits of each field on a write
   property p_wr6;
      @(posedge sys_clk) disable iff (!resetn)
      (hit_wr && VARIANT == SPC_VAR_POST6) |=>
         packed_ptrs == ($past(bus.wdata) & {SPC_MASK_6, SPC_MASK_6});
   endproperty
   a_wr6: assert property (p_wr6) else $error("masked write not loaded");

   // Read data stands until the next read, so software may sample it late
   property p_rd_hold;
      @(posedge sys_clk) disable iff (!resetn)
      !hit_rd |=> $stable(rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");

   // With no request at all both pointers keep their value
   property p_idle_hold;
      @(posedge sys_clk) disable iff (!resetn)
      (!hit_wr && !hit_rd && pstack_op == '0 && rstack_op == '0) |=> $stable(packed_ptrs);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("pointers drifted");

   // The read result lands on the parameter stack only
   property p_rsp_keep;
      @(posedge sys_clk) disable iff (!resetn)
      (hit_rd && !hit_wr && rstack_op == '0) |=> $stable(rsp);
   endproperty
   a_rsp_keep: assert property (p_rsp_keep) else $error("read moved return ptr");

   // A read together with a core push is still one push, never two
   property p_rd_once;
      @(posedge sys_clk) disable iff (!resetn)
      (hit_rd && !hit_wr && pstack_op.push && !pstack_op.pop) |=>
         ((psp - $past(psp)) & SPC_MASK_6) == SPC_ONE;
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("read push counted twice");

   // Pre-increment read stores its value one above the current pointer
   property p_pre_rd;
      @(posedge sys_clk) disable iff (!resetn)
      (VARIANT == SPC_VAR_PRE8 && hit_rd) |-> pstack_addr == psp + SPC_ONE;
   endproperty
   a_pre_rd: assert property (p_pre_rd) else $error("pre read addr");

   // Pre-increment pop reads at the pointer itself
   property p_pre_pop;
      @(posedge sys_clk) disable iff (!resetn)
      (VARIANT == SPC_VAR_PRE8 && rstack_op.pop && !rstack_op.push) |-> rstack_addr == rsp;
   endproperty
   a_pre_pop: assert property (p_pre_pop) else $error("pre pop addr");

   // Post-increment push writes at the pointer itself
   property p_post_push;
      @(posedge sys_clk) disable iff (!resetn)
      (VARIANT != SPC_VAR_PRE8 && rstack_op.push && !rstack_op.pop) |-> rstack_addr == rsp;
   endproperty
   a_post_push: assert property (p_post_push) else $error("post push addr");

   // A 6-bit build never addresses beyond its 64 locations
   property p_span6;
      @(posedge sys_clk) disable iff (!resetn)
      (VARIANT == SPC_VAR_POST6) |-> ((pstack_addr | rstack_addr) & ~SPC_MASK_6) == 8'h00;
   endproperty
   a_span6: assert property (p_span6) else $error("address out of span");

   // Post builds never raise underflow; the item count is kept but the flag is held at zero
   property p_post_nouf;
      @(posedge sys_clk) disable iff (!resetn)
      (VARIANT != SPC_VAR_PRE8) |-> underflow_req == 2'h0;
   endproperty
   a_post_nouf: assert property (p_post_nouf) else $error("post underflow");

   // A parameter underflow only follows a parameter pop
   property p_puf_src;
      @(posedge sys_clk) disable iff (!resetn)
      underflow_req[0] |-> ($past(p_op_eff.pop) && !$past(hit_wr));
   endproperty
   a_puf_src: assert property (p_puf_src) else $error("stray param underflow");

   // A return underflow only follows a return pop
   property p_ruf_src;
      @(posedge sys_clk) disable iff (!resetn)
      underflow_req[1] |-> ($past(rstack_op.pop) && !$past(hit_wr));
   endproperty
   a_ruf_src: assert property (p_ruf_src) else $error("stray return underflow");

   // Push and pop in one cycle cancel, so the pointer stays put
   property p_cancel;
      @(posedge sys_clk) disable iff (!resetn)
      (rstack_op.push && rstack_op.pop && !hit_wr) |=> $stable(rsp);
   endproperty
   a_cancel: assert property (p_cancel) else $error("push and pop moved ptr");

   // A write restarts item counting, so it can never raise underflow
   property p_wr_nouf;
      @(posedge sys_clk) disable iff (!resetn)
      hit_wr |=> underflow_req == 2'h0;
   endproperty
   a_wr_nouf: assert property (p_wr_nouf) else $error("underflow after write");
endmodule // spc_top

// ---- core/spc_pkg.sv ----
package spc_pkg;
   // Peripheral bus address of the combined pointer register
   localparam logic [3:0] SPC_ADDR_STACK_POINTERS = 4'h9;
   localparam logic [15:0] SPC_RESET_VALUE = 16'h0000;
   // Field positions inside the combined register
   localparam int SPC_PSP_LSB = 0;
   localparam int SPC_RSP_LSB = 8;
   localparam int SPC_FIELD_W = 8;
   // Pointer masks per variant
   localparam logic [7:0] SPC_MASK_8 = 8'hFF;
   localparam logic [7:0] SPC_MASK_6 = 8'h3F;
   localparam logic [7:0] SPC_ONE = 8'h01;
   localparam logic [8:0] SPC_CNT_ONE = 9'h001;
   localparam logic [8:0] SPC_CNT_ZERO = 9'h000;

   // Build-time variant selection
   typedef enum logic [1:0] {
      SPC_VAR_PRE8 = 2'h0,
      SPC_VAR_POST6 = 2'h1,
      SPC_VAR_POST8 = 2'h3
   } spc_variant_t;

   // Stack operation request from the core to one controller
   typedef struct packed {
      logic push;
      logic pop;
   } spc_op_t;

   // Peripheral bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [15:0] wdata;
   } spc_bus_t;
endpackage

// ---- core/spc_ctrl.sv ----
`timescale 1ns/100ps
// One stack controller: pointer, access address and underflow tracking
module spc_ctrl
   import spc_pkg::*;
#(
   parameter spc_variant_t VARIANT = SPC_VAR_PRE8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire spc_op_t op,
   input wire logic load,
   input wire logic [7:0] load_val,
   output logic [7:0] ptr,
   output logic [7:0] mem_addr,
   output logic underflow
);
   typedef struct packed {
      logic [7:0] ptr;
      logic [8:0] count;
      logic uflow;
   } spc_ctrl_state_t;

   spc_ctrl_state_t state_reg;
   spc_ctrl_state_t state_next;
   logic [7:0] mask;
   logic is_pre;

   assign mask = (VARIANT == SPC_VAR_POST6) ? SPC_MASK_6 : SPC_MASK_8;
   assign is_pre = (VARIANT == SPC_VAR_PRE8);

   // Pointer update; masking gives circular wrap in both directions
   always_comb begin
      state_next = state_reg;
      state_next.uflow = 1'b0;
      if (load) begin
         state_next.ptr = load_val & mask;
         state_next.count = SPC_CNT_ZERO;
      end else if (op.push && !op.pop) begin
         state_next.ptr = (state_reg.ptr + SPC_ONE) & mask;
         state_next.count = state_reg.count + SPC_CNT_ONE;
      end else if (op.pop && !op.push) begin
         state_next.ptr = (state_reg.ptr - SPC_ONE) & mask;
         if (state_reg.count == SPC_CNT_ZERO) begin
            state_next.uflow = is_pre;
         end else begin
            state_next.count = state_reg.count - SPC_CNT_ONE;
         end
      end
   end

   // Pre variant accesses new pointer on push, current on pop; post variant the reverse
   always_comb begin
      if (is_pre) begin
         mem_addr = op.push ? ((state_reg.ptr + SPC_ONE) & mask) : state_reg.ptr;
      end else begin
         mem_addr = op.pop ? ((state_reg.ptr - SPC_ONE) & mask) : state_reg.ptr;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ptr = state_reg.ptr;
   assign underflow = state_reg.uflow;

   property p_push_inc;
      @(posedge sys_clk) disable iff (!resetn)
      (op.push && !op.pop && !load) |=> ptr == ((($past(ptr)) + SPC_ONE) & mask);
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push did not advance pointer");

   property p_pop_dec;
      @(posedge sys_clk) disable iff (!resetn)
      (op.pop && !op.push && !load) |=> ptr == ((($past(ptr)) - SPC_ONE) & mask);
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop did not retreat pointer");

   property p_load;
      @(posedge sys_clk) disable iff (!resetn)
      load |=> ptr == ($past(load_val) & mask);
   endproperty
   a_load: assert property (p_load) else $error("load value not taken");

   property p_post_pop_addr;
      @(posedge sys_clk) disable iff (!resetn)
      (!is_pre && op.pop) |-> mem_addr == ((ptr - SPC_ONE) & mask);
   endproperty
   a_post_pop_addr: assert property (p_post_pop_addr) else $error("post pop address");

   property p_uflow;
      @(posedge sys_clk) disable iff (!resetn)
      (is_pre && op.pop && !op.push && !load && state_reg.count == SPC_CNT_ZERO) |=> underflow;
   endproperty
   a_uflow: assert property (p_uflow) else $error("underflow not raised");

   property p_range;
      @(posedge sys_clk) disable iff (!resetn)
      (ptr & ~mask) == 8'h00;
   endproperty
   a_range: assert property (p_range) else $error("pointer out of range");
endmodule // spc_ctrl

// ---- sim/spc_core_model.sv ----
`timescale 1ns/100ps
// Core side of the peripheral bus and stack op lines; one call drives one cycle
module spc_core_model
   import spc_pkg::*;
(
   input wire logic sys_clk,
   output spc_bus_t bus,
   output spc_op_t pstack_op,
   output spc_op_t rstack_op
);
   initial begin
      bus = '0;
      pstack_op = '0;
      rstack_op = '0;
   end
   // Falling-edge changes keep clear of the sampling edge
   task automatic step(input spc_bus_t b, input spc_op_t p, input spc_op_t r);
      @(negedge sys_clk);
      if (!b.wr) begin
         b.wdata = ~bus.wdata; // Idle data never repeats the last word
      end
      bus = b;
      pstack_op = p;
      rstack_op = r;
   endtask
endmodule // spc_core_model

// ---- sim/spc_top_test.sv ----
`timescale 1ns/100ps
module spc_top_test;
   import spc_pkg::*;
   localparam spc_op_t PU = 2'h2;
   localparam spc_op_t PO = 2'h1;
   localparam spc_op_t NO = 2'h0;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   spc_bus_t bus;
   spc_op_t pstack_op;
   spc_op_t rstack_op;
   logic [15:0] rdata;
   logic [1:0] underflow_req;
   logic [15:0] rdata6;
   logic [15:0] rdata8;
   logic [1:0] uf6;
   logic [1:0] uf8;
   logic [7:0] pa;
   logic [7:0] ra;
   logic [7:0] pa6;
   logic [7:0] ra6;
   logic [7:0] pa8;
   logic [7:0] ra8;
   logic [31:0] qa[$];
   logic [31:0] ea;
   logic [15:0] er;
   logic [15:0] q[$];
   logic [15:0] last = 16'h0000;
   logic [7:0] psp = 8'h00;
   logic [7:0] rsp = 8'h00;
   logic [1:0] uf_exp = 2'h0;
   logic [1:0] uf_pend = 2'h0;
   logic rd_pend = 1'h0;
   int pcnt = 0;
   int rcnt = 0;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   spc_core_model core (.sys_clk(sys_clk), .bus(bus), .pstack_op(pstack_op),
      .rstack_op(rstack_op));
   spc_top dut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
      .pstack_op(pstack_op), .rstack_op(rstack_op), .pstack_addr(pa), .rstack_addr(ra),
      .underflow_req(underflow_req));
   // The post builds share the stimulus; 64 divides 256, so one model serves all
   spc_top #(.VARIANT(SPC_VAR_POST6)) dut_post6 (.sys_clk(sys_clk), .resetn(resetn),
      .bus(bus), .rdata(rdata6), .pstack_op(pstack_op), .rstack_op(rstack_op),
      .pstack_addr(pa6), .rstack_addr(ra6), .underflow_req(uf6));
   spc_top #(.VARIANT(SPC_VAR_POST8)) dut_post8 (.sys_clk(sys_clk), .resetn(resetn),
      .bus(bus), .rdata(rdata8), .pstack_op(pstack_op), .rstack_op(rstack_op),
      .pstack_addr(pa8), .rstack_addr(ra8), .underflow_req(uf8));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Reference pointer model; a read counts as one parameter push
   task automatic upd(input spc_op_t o, input logic rp, inout logic [7:0] ptr,
      inout int cnt, output logic uf);
      uf = 1'h0;
      if ((o.push && !o.pop) || rp) begin
         ptr++;
         cnt++;
      end else if (o.pop && !o.push) begin
         uf = (cnt == 0);
         ptr--;
         cnt = (cnt == 0) ? 0 : cnt - 1;
      end
   endtask

   // One bus cycle plus ops; the note is taken once the request is on the pins
   task automatic cyc(input logic rd, input logic wr, input logic [3:0] a,
      input logic [15:0] d, input spc_op_t p, input spc_op_t r);
      logic hit;
      hit = (a == SPC_ADDR_STACK_POINTERS);
      core.step({rd, wr, a, d}, p, r);
      // Access addresses from the pointers before this cycle's update
      qa.push_back({rsp + {7'h00, r.push}, psp + {7'h00, p.push | (rd & hit)},
         rsp - {7'h00, r.pop}, psp - {7'h00, p.pop}});
      if (rd) begin
         q.push_back(hit ? {rsp, psp} : last);
         last = q[$];
      end
      if (wr && hit) begin
         {rsp, psp} = d;
         pcnt = 0;
         rcnt = 0;
         uf_exp = 2'h0;
      end else begin
         upd(p, rd && hit, psp, pcnt, uf_exp[0]);
         upd(r, 1'h0, rsp, rcnt, uf_exp[1]);
      end
   endtask

   // Results land on the edge after the request and are read at the fall
   always @(posedge sys_clk) begin
      rd_pend <= bus.rd && resetn;
      uf_pend <= uf_exp;
      cycles <= cycles + 1;
   end
   always @(negedge sys_clk) begin
      if (resetn && rd_pend) begin
         er = q.pop_front();
         check(rdata, er);
         check(rdata8, er);
         check(rdata6, er & {SPC_MASK_6, SPC_MASK_6});
      end
      if (resetn) check({14'h0000, underflow_req}, {14'h0000, uf_pend});
      if (resetn) check({12'h000, uf6, uf8}, 16'h0000);
      if (cycles > 1000) begin
         num_errors++;
         test_done();
      end
   end

   // Addresses are combinational; look 20 ns after the falling edge that moved the inputs
   always @(negedge sys_clk) begin
      #20;
      if (resetn && qa.size() > 0) begin
         ea = qa.pop_front();
         check({ra, pa}, ea[31:16]);
         check({ra8, pa8}, ea[15:0]);
         check({ra6, pa6}, ea[15:0] & {SPC_MASK_6, SPC_MASK_6});
      end
   end

   initial begin
      void'($urandom(32'hD01091EE));
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'h1;
      cyc(1'h1, 1'h0, 4'h9, 16'h0000, NO, NO);
      for (int i = 0; i < 4; i++) begin
         cyc(1'h0, 1'h1, 4'h9, 16'($urandom), NO, NO);
         cyc(1'h1, 1'h0, 4'h9, 16'h0000, NO, NO);
         cyc(1'h1, 1'h0, 4'h9, 16'h0000, NO, NO);
      end
      // Back-to-back pushes wrap both pointers past the top
      cyc(1'h0, 1'h1, 4'h9, 16'hFEFD, NO, NO);
      repeat (3) cyc(1'h0, 1'h0, 4'h9, 16'h0000, PU, PU);
      cyc(1'h1, 1'h0, 4'h9, 16'h0000, NO, NO);
      // Pops from empty stacks wrap down and raise both requests
      cyc(1'h0, 1'h1, 4'h9, 16'h0000, NO, NO);
      cyc(1'h0, 1'h0, 4'h9, 16'h0000, PO, PO);
      cyc(1'h1, 1'h0, 4'h9, 16'h0000, PU, PU);
      cyc(1'h0, 1'h0, 4'h9, 16'h0000, PO, PO);
      cyc(1'h0, 1'h0, 4'h9, 16'h0000, 2'h3, 2'h3);
      // Unmapped address leaves pointers and read data alone
      cyc(1'h0, 1'h1, 4'h8, 16'h1234, NO, NO);
      cyc(1'h1, 1'h0, 4'h8, 16'h0000, NO, NO);
      cyc(1'h1, 1'h0, 4'h9, 16'h0000, NO, NO);
      // Random mix; no parameter pop alongside a read
      repeat (30) cyc(1'h1, 1'h0, 4'h9, 16'h0000, spc_op_t'(2'($urandom) & 2'h2),
         spc_op_t'(2'($urandom)));
      repeat (2) cyc(1'h0, 1'h0, 4'h9, 16'h0000, NO, NO);
      test_done();
   end
endmodule // spc_top_test
